// ==== testbench/fmac_host_model.sv ====
// Host model: issues control port writes and reads one at a time
`timescale 1ns/1ns
module fmac_host_model import fmac_pkg::*; (
  input  wire logic       clk,
  output fmac_req_t       req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;
  // Idle address and data show junk so a stale value is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Answer is taken once it has settled after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1;
    ok = rvalid;
    d = rdata;
  endtask
endmodule

// ==== testbench/fmac_regs_checker.sv ====
// Checker: port properties of the fault mask and converter control registers
`timescale 1ns/1ns
module fmac_regs_checker import fmac_pkg::*; (
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire fmac_req_t  BUS_REQ,
  input wire logic [7:0] BUS_RDATA,
  input wire logic       REG_RESET,
  input wire logic       WATCHDOG_EXPIRED,
  input wire logic [7:0] FAULT_EVENTS,
  input wire logic       CONV_PASS_DONE,
  input wire logic       INT_ACTIVE,
  input wire fmac_conv_t CONV_CFG,
  input wire logic       CONV_RUN,
  input wire logic [4:0] CONV_RES_BITS
);
  // Control settings as they read back, bit 1 fixed low
  logic [7:0] cfg_byte;
  assign cfg_byte = {CONV_CFG[6:1], 1'b0, CONV_CFG[0]};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Control write with no clear or pass end competing for the register
  sequence s_cfg_wr;
    BUS_REQ.wr && BUS_REQ.addr == FMAC_ADDR_CONV_CTRL && !REG_RESET && !WATCHDOG_EXPIRED && !CONV_PASS_DONE;
  endsequence
  sequence s_rd(logic [7:0] a);
    BUS_REQ.rd && BUS_REQ.addr == a;
  endsequence
  property p_part; s_rd(FMAC_ADDR_PART_ID) |=> BUS_RDATA == {FMAC_PART_UPPER, FMAC_VARIANT_CODE}; endproperty
  property p_ctrl_rd; s_rd(FMAC_ADDR_CONV_CTRL) |=> BUS_RDATA == $past(cfg_byte); endproperty
  property p_cfg_wr; s_cfg_wr |=> cfg_byte == ($past(BUS_REQ.wdata) & FMAC_CONV_WR_MASK); endproperty
  property p_run; s_cfg_wr ##0 BUS_REQ.wdata[7] |=> ##[0:1] CONV_RUN; endproperty
  property p_wd; WATCHDOG_EXPIRED |=> !CONV_CFG.enable; endproperty
  property p_rr; REG_RESET |=> cfg_byte == 8'h00; endproperty
  property p_res;
    CONV_CFG.speed == $past(CONV_CFG.speed) |-> CONV_RES_BITS == 5'h0F - {3'h0, CONV_CFG.speed};
  endproperty
  // A new interrupt needs a recent event or a recent bus write to any address
  property p_irq;
    $rose(INT_ACTIVE) |-> $past(FAULT_EVENTS) != 8'h00 || $past(FAULT_EVENTS, 2) != 8'h00
      || $past(BUS_REQ.wr) || $past(BUS_REQ.wr, 2);
  endproperty
  a_part: assert property (p_part) else $error("part code wrong");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read back wrong");
  a_cfg_wr: assert property (p_cfg_wr) else $error("control write lost");
  a_run: assert property (p_run) else $error("converter not started");
  a_wd: assert property (p_wd) else $error("watchdog kept enable");
  a_rr: assert property (p_rr) else $error("register reset kept control");
  a_res: assert property (p_res) else $error("resolution wrong");
  a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule

bind fmac_regs fmac_regs_checker fmac_regs_checker_i (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
  .REG_RESET(REG_RESET), .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED), .FAULT_EVENTS(FAULT_EVENTS),
  .CONV_PASS_DONE(CONV_PASS_DONE), .INT_ACTIVE(INT_ACTIVE), .CONV_CFG(CONV_CFG),
  .CONV_RUN(CONV_RUN), .CONV_RES_BITS(CONV_RES_BITS)
);

// ==== testbench/fmac_regs_tb_top.sv ====
// Testbench: reference model of masks, flags and converter control against the design
`timescale 1ns/1ns
module fmac_regs_tb_top import fmac_pkg::*;;
  logic       clk, rst_n, rvalid, reg_reset, wd, pass_done, int_active, run, ok, seed_fresh, ibus_en;
  logic [7:0] rdata, ev, rd_v, w;
  logic [4:0] res_bits;
  fmac_req_t  req;
  fmac_conv_t cfg;
  int         n_fail, total_checks, mask_m, ctrl_m, i;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  fmac_regs fmac_regs_i (.CLK_SYS(clk), .RST_N(rst_n), .BUS_REQ(req), .BUS_RDATA(rdata),
    .BUS_RVALID(rvalid), .REG_RESET(reg_reset), .WATCHDOG_EXPIRED(wd), .FAULT_EVENTS(ev),
    .CONV_PASS_DONE(pass_done), .INT_ACTIVE(int_active), .CONV_CFG(cfg), .CONV_RUN(run),
    .CONV_SEED_FRESH(seed_fresh), .CONV_IBUS_EN(ibus_en), .CONV_RES_BITS(res_bits));
  fmac_host_model fmac_host_model_i (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read answers must come with the valid pulse
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    fmac_host_model_i.rd(a, rd_v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rd_v, exp);
  endtask
  // Events last one cycle; two more edges let the interrupt settle
  task automatic pulse_ev(input logic [7:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 8'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #300000;
    n_fail++;
    print_verdict;
  end

  initial begin
    rst_n = 1'b0;
    reg_reset = 1'b0;
    wd = 1'b0;
    pass_done = 1'b0;
    ev = 8'h00;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(32'hE479));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc(FMAC_ADDR_FAULT_MASK, 8'h00);
    rdc(FMAC_ADDR_PART_ID, {FMAC_PART_UPPER, FMAC_VARIANT_CODE});
    rdc(FMAC_ADDR_CONV_CTRL, 8'h00);
    rdc(8'h3C, FMAC_UNMAPPED_READ);
    chk({3'h0, res_bits}, 8'h0F);
    $display("test reset values done");
    // Random settings; the part code write must be ignored
    for (i = 0; i < 20; i++) begin
      w = 8'($urandom());
      fmac_host_model_i.wr(FMAC_ADDR_FAULT_MASK, w);
      mask_m = w;
      w = 8'($urandom());
      fmac_host_model_i.wr(FMAC_ADDR_CONV_CTRL, w);
      ctrl_m = w & 8'hFD;
      fmac_host_model_i.wr(FMAC_ADDR_PART_ID, w);
      rdc(FMAC_ADDR_FAULT_MASK, 8'(mask_m));
      rdc(FMAC_ADDR_CONV_CTRL, 8'(ctrl_m));
      rdc(FMAC_ADDR_PART_ID, {FMAC_PART_UPPER, FMAC_VARIANT_CODE});
      chk({cfg[6:1], 1'b0, cfg[0]}, 8'(ctrl_m));
      chk({3'h0, res_bits}, 8'(15 - ((ctrl_m >> 2) & 3)));
      chk({7'h00, run}, 8'(ctrl_m >> 7));
      chk({7'h00, ibus_en}, 8'((ctrl_m >> 7) & ~ctrl_m & 1));
      // No pass ends here, so a running converter is still on its first pass
      if ((ctrl_m >> 7) & 1) chk({7'h00, seed_fresh}, 8'((ctrl_m >> 5) & (ctrl_m >> 4) & 1));
    end
    $display("test random settings done");
    // Each fault alone, unmasked then masked
    rdc(FMAC_ADDR_FAULT_FLAG, 8'h00);
    for (i = 0; i < 8; i++) begin
      fmac_host_model_i.wr(FMAC_ADDR_FAULT_MASK, ~(8'h01 << i));
      pulse_ev(8'h01 << i);
      chk({7'h00, int_active}, 8'h01);
      rdc(FMAC_ADDR_FAULT_FLAG, 8'h01 << i);
      rdc(FMAC_ADDR_FAULT_FLAG, 8'h00);
      chk({7'h00, int_active}, 8'h00);
      fmac_host_model_i.wr(FMAC_ADDR_FAULT_MASK, 8'h01 << i);
      pulse_ev(8'h01 << i);
      chk({7'h00, int_active}, 8'h00);
      rdc(FMAC_ADDR_FAULT_FLAG, 8'h01 << i);
    end
    $display("test fault masking done");
    // Watchdog spares the mask; register reset clears all
    fmac_host_model_i.wr(FMAC_ADDR_FAULT_MASK, 8'h5A);
    fmac_host_model_i.wr(FMAC_ADDR_CONV_CTRL, 8'hFF);
    @(posedge clk) wd <= 1'b1;
    @(posedge clk) wd <= 1'b0;
    rdc(FMAC_ADDR_FAULT_MASK, 8'h5A);
    rdc(FMAC_ADDR_CONV_CTRL, 8'h7D);
    pulse_ev(8'h81);
    chk({7'h00, int_active}, 8'h01);
    @(posedge clk) reg_reset <= 1'b1;
    @(posedge clk) reg_reset <= 1'b0;
    rdc(FMAC_ADDR_FAULT_MASK, 8'h00);
    rdc(FMAC_ADDR_CONV_CTRL, 8'h00);
    rdc(FMAC_ADDR_FAULT_FLAG, 8'h00);
    chk({7'h00, int_active}, 8'h00);
    // One-shot stops after its pass, continuous keeps running
    for (i = 0; i < 2; i++) begin
      fmac_host_model_i.wr(FMAC_ADDR_CONV_CTRL, i ? 8'h80 : 8'hC0);
      @(posedge clk) pass_done <= 1'b1;
      @(posedge clk) pass_done <= 1'b0;
      rdc(FMAC_ADDR_CONV_CTRL, i ? 8'h80 : 8'h40);
      chk({7'h00, run}, i ? 8'h01 : 8'h00);
    end
    // Fresh seed holds for the first averaging pass of a new run only
    fmac_host_model_i.wr(FMAC_ADDR_CONV_CTRL, 8'h00);
    fmac_host_model_i.wr(FMAC_ADDR_CONV_CTRL, 8'hB0);
    rdc(FMAC_ADDR_CONV_CTRL, 8'hB0);
    chk({7'h00, seed_fresh}, 8'h01);
    @(posedge clk) pass_done <= 1'b1;
    @(posedge clk) pass_done <= 1'b0;
    rdc(FMAC_ADDR_CONV_CTRL, 8'hB0);
    chk({6'h00, seed_fresh, run}, 8'h01);
    chk({7'h00, ibus_en}, 8'h01);
    $display("test clears and conversion rate done");
    print_verdict;
  end
endmodule

// ==== verilog/fmac_conv_sched.sv ====
// Converter sequencing: run, one-shot pass, averaging seed and channel enables
`timescale 1ns/1ns
module fmac_conv_sched import fmac_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire fmac_conv_t cfg,
  input  wire logic       pass_done,
  output logic            run_d,
  output logic            seed_fresh_d,
  output logic            ibus_en_d,
  output logic [4:0]      res_bits_d,
  output logic            oneshot_done
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} fmac_sched_t;
  fmac_sched_t state_q;
  fmac_sched_t state_d;
  logic        first_q;
  logic        first_d;

  // Next state: one-shot stops after one pass, continuous keeps going
  always_comb begin
    state_d      = state_q;
    first_d      = first_q;
    oneshot_done = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (cfg.enable) begin
          state_d = ST_RUN;
          first_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (!cfg.enable) begin
          state_d = ST_IDLE;
        end else if (pass_done) begin
          first_d = 1'b0;
          if (cfg.one_shot) begin
            state_d      = ST_HOLD;
            oneshot_done = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // Held until the enable drops or one-shot is cleared; avoids repeat passes
        if (!cfg.enable) begin
          state_d = ST_IDLE;
        end else if (!cfg.one_shot) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      first_q <= 1'b0;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
    end
  end

  assign run_d        = (state_d == ST_RUN);
  // Fresh seed only matters on the first pass of an averaging run
  assign seed_fresh_d = cfg.average & cfg.seed_fresh & first_d;
  assign ibus_en_d    = (state_d == ST_RUN) & ~cfg.ibus_disable;
  assign res_bits_d   = fmac_res_bits(cfg.speed);
endmodule

// ==== verilog/fmac_flags.sv ====
// Sticky fault flags with clear on read and mask gated interrupt request
`timescale 1ns/1ns
module fmac_flags (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       soft_rst,
  input  wire logic [7:0] events,
  input  wire logic       flag_read,
  input  wire logic [7:0] mask,
  output logic      [7:0] flags,
  output logic            irq_d
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // Per bit latch; a new event beats the read clear so nothing is lost
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_flag
      always_comb begin
        if (events[i]) begin
          flags_d[i] = 1'b1;
        end else if (flag_read || soft_rst) begin
          flags_d[i] = 1'b0;
        end else begin
          flags_d[i] = flags_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;
  // Masked flags never reach the pin
  assign irq_d = |(flags_d & ~mask);
endmodule

// ==== verilog/fmac_pkg.sv ====
// Package: register map, field layout and shared types of the fault mask and converter control block
package fmac_pkg;

  // Register addresses on the control port
  localparam logic [7:0] FMAC_ADDR_FAULT_MASK = 8'h12;
  localparam logic [7:0] FMAC_ADDR_PART_ID    = 8'h13;
  localparam logic [7:0] FMAC_ADDR_CONV_CTRL  = 8'h14;
  localparam logic [7:0] FMAC_ADDR_FAULT_FLAG = 8'h11;

  // Fault bit positions, shared by mask and flag registers
  localparam int FMAC_BIT_BAT_OV   = 7;
  localparam int FMAC_BIT_BAT_OC   = 6;
  localparam int FMAC_BIT_IN_OV    = 5;
  localparam int FMAC_BIT_IN_OC    = 4;
  localparam int FMAC_BIT_TS_NEAR  = 3;
  localparam int FMAC_BIT_BAT_TEMP = 2;
  localparam int FMAC_BIT_CON_TEMP = 1;
  localparam int FMAC_BIT_DIE_TEMP = 0;

  // Converter control field positions
  localparam int FMAC_CC_ENABLE   = 7;
  localparam int FMAC_CC_ONE_SHOT = 6;
  localparam int FMAC_CC_AVERAGE  = 5;
  localparam int FMAC_CC_SEED     = 4;
  localparam int FMAC_CC_SPEED_HI = 3;
  localparam int FMAC_CC_SPEED_LO = 2;
  localparam int FMAC_CC_IBUS_DIS = 0;

  // Reset values and fixed read values
  localparam logic [7:0] FMAC_RST_FAULT_MASK = 8'h00;
  localparam logic [7:0] FMAC_RST_CONV_CTRL  = 8'h00;
  localparam logic [3:0] FMAC_PART_UPPER     = 4'h1;
  localparam logic [7:0] FMAC_CONV_WR_MASK   = 8'hFD;
  localparam logic [7:0] FMAC_UNMAPPED_READ  = 8'h00;

  // Variant code; value is arbitrary
  localparam logic [3:0] FMAC_VARIANT_CODE = 4'hA;

  // Effective resolution encodings
  localparam logic [1:0] FMAC_RES_15 = 2'h0;
  localparam logic [1:0] FMAC_RES_14 = 2'h1;
  localparam logic [1:0] FMAC_RES_13 = 2'h2;
  localparam logic [1:0] FMAC_RES_12 = 2'h3;

  // Register bus access from the control port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmac_req_t;

  // Decoded converter settings
  typedef struct packed {
    logic       enable;
    logic       one_shot;
    logic       average;
    logic       seed_fresh;
    logic [1:0] speed;
    logic       ibus_disable;
  } fmac_conv_t;

  // Number of result bits for a speed code
  function automatic logic [4:0] fmac_res_bits(input logic [1:0] speed);
    unique case (speed)
      FMAC_RES_15: fmac_res_bits = 5'h0F;
      FMAC_RES_14: fmac_res_bits = 5'h0E;
      FMAC_RES_13: fmac_res_bits = 5'h0D;
      FMAC_RES_12: fmac_res_bits = 5'h0C;
    endcase
  endfunction

endpackage

// ==== verilog/fmac_regs.sv ====
// Top: fault mask, part identification and converter control registers
`timescale 1ns/1ns
module fmac_regs import fmac_pkg::*; (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  input  wire fmac_req_t  BUS_REQ,
  output logic      [7:0] BUS_RDATA,
  output logic            BUS_RVALID,
  input  wire logic       REG_RESET,
  input  wire logic       WATCHDOG_EXPIRED,
  input  wire logic [7:0] FAULT_EVENTS,
  input  wire logic       CONV_PASS_DONE,
  output logic            INT_ACTIVE,
  output fmac_conv_t      CONV_CFG,
  output logic            CONV_RUN,
  output logic            CONV_SEED_FRESH,
  output logic            CONV_IBUS_EN,
  output logic      [4:0] CONV_RES_BITS
);
  logic [7:0] fault_mask_q;
  logic [7:0] fault_mask_d;
  logic [7:0] conv_ctrl_q;
  logic [7:0] conv_ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       irq_q;
  logic       irq_d;
  logic       run_q;
  logic       run_d;
  logic       seed_q;
  logic       seed_d;
  logic       ibus_q;
  logic       ibus_d;
  logic [4:0] res_q;
  logic [4:0] res_d;
  logic [7:0] flags;
  logic       flag_read;
  logic       oneshot_done;
  fmac_conv_t cfg;

  // Address decode shared by read and write paths
  function automatic logic hit(input fmac_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  assign flag_read = BUS_REQ.rd & hit(BUS_REQ, FMAC_ADDR_FAULT_FLAG);

  // Mask register; watchdog deliberately has no effect here
  always_comb begin
    fault_mask_d = fault_mask_q;
    if (REG_RESET) begin
      fault_mask_d = FMAC_RST_FAULT_MASK;
    end else if (BUS_REQ.wr && hit(BUS_REQ, FMAC_ADDR_FAULT_MASK)) begin
      fault_mask_d = BUS_REQ.wdata;
    end
  end

  // Converter control; reserved bit 1 is never stored
  always_comb begin
    conv_ctrl_d = conv_ctrl_q;
    if (REG_RESET) begin
      conv_ctrl_d = FMAC_RST_CONV_CTRL;
    end else begin
      if (BUS_REQ.wr && hit(BUS_REQ, FMAC_ADDR_CONV_CTRL)) begin
        conv_ctrl_d = BUS_REQ.wdata & FMAC_CONV_WR_MASK;
      end
      if (oneshot_done) begin
        // Pass finished: enable drops so software sees the shot complete
        conv_ctrl_d[FMAC_CC_ENABLE] = 1'b0;
      end
      if (WATCHDOG_EXPIRED) begin
        conv_ctrl_d[FMAC_CC_ENABLE] = 1'b0;
      end
    end
  end

  assign cfg.enable       = conv_ctrl_q[FMAC_CC_ENABLE];
  assign cfg.one_shot     = conv_ctrl_q[FMAC_CC_ONE_SHOT];
  assign cfg.average      = conv_ctrl_q[FMAC_CC_AVERAGE];
  assign cfg.seed_fresh   = conv_ctrl_q[FMAC_CC_SEED];
  assign cfg.speed        = conv_ctrl_q[FMAC_CC_SPEED_HI:FMAC_CC_SPEED_LO];
  assign cfg.ibus_disable = conv_ctrl_q[FMAC_CC_IBUS_DIS];

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_d = rdata_q;
    if (BUS_REQ.rd) begin
      unique case (BUS_REQ.addr)
        FMAC_ADDR_FAULT_MASK: rdata_d = fault_mask_q;
        FMAC_ADDR_PART_ID:    rdata_d = {FMAC_PART_UPPER, FMAC_VARIANT_CODE};
        FMAC_ADDR_CONV_CTRL:  rdata_d = conv_ctrl_q & FMAC_CONV_WR_MASK;
        FMAC_ADDR_FAULT_FLAG: rdata_d = flags;
        default:              rdata_d = FMAC_UNMAPPED_READ;
      endcase
    end
  end

  fmac_flags u_flags (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .soft_rst  (REG_RESET),
    .events    (FAULT_EVENTS),
    .flag_read (flag_read),
    .mask      (fault_mask_q),
    .flags     (flags),
    .irq_d     (irq_d)
  );

  fmac_conv_sched u_sched (
    .clk          (CLK_SYS),
    .rst_n        (RST_N),
    .cfg          (cfg),
    .pass_done    (CONV_PASS_DONE),
    .run_d        (run_d),
    .seed_fresh_d (seed_d),
    .ibus_en_d    (ibus_d),
    .res_bits_d   (res_d),
    .oneshot_done (oneshot_done)
  );

  // Registers and all outputs registered here; flags and sequencer state are in the submodules
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fault_mask_q <= FMAC_RST_FAULT_MASK;
      conv_ctrl_q  <= FMAC_RST_CONV_CTRL;
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
      irq_q        <= 1'b0;
      run_q        <= 1'b0;
      seed_q       <= 1'b0;
      ibus_q       <= 1'b0;
      res_q        <= 5'h0F;
    end else begin
      fault_mask_q <= fault_mask_d;
      conv_ctrl_q  <= conv_ctrl_d;
      rdata_q      <= rdata_d;
      rvalid_q     <= BUS_REQ.rd;
      irq_q        <= irq_d;
      run_q        <= run_d;
      seed_q       <= seed_d;
      ibus_q       <= ibus_d;
      res_q        <= res_d;
    end
  end

  assign BUS_RDATA       = rdata_q;
  assign BUS_RVALID      = rvalid_q;
  assign INT_ACTIVE      = irq_q;
  assign CONV_CFG        = cfg;
  assign CONV_RUN        = run_q;
  assign CONV_SEED_FRESH = seed_q;
  assign CONV_IBUS_EN    = ibus_q;
  assign CONV_RES_BITS   = res_q;
endmodule
